// ---- shared/csl_decode_pkg.sv ----
// Constants shared by the select-code decoder and its input latch.
// Assumes a single 100 MHz clock; all inputs are synchronous to it.
package select_decode_pkg;
  // Widths of the latched input word: enable plus the five code lines
  localparam int CODE_W = 5;
  localparam int LATCH_W = 6;
  // Number of individual decoded outputs
  localparam int OUT_W = 23;
  // Bit positions inside the decoded output vector (active-high form)
  localparam int O_ROM = 0;
  localparam int O_KBC = 1;
  localparam int O_NPU = 2;
  localparam int O_PCU0 = 3;
  localparam int O_PCU1 = 4;
  localparam int O_KACK = 5;
  localparam int O_RTCALE = 6;
  localparam int O_RTCWR = 7;
  localparam int O_RTCRD = 8;
  localparam int O_FDOR = 9;
  localparam int O_FLOPPY = 10;
  localparam int O_FDCR = 11;
  localparam int O_IDEL = 12;
  localparam int O_IDEH = 13;
  localparam int O_IDECMD = 14;
  localparam int O_IDECTL = 15;
  localparam int O_SERA = 16;
  localparam int O_SERB = 17;
  localparam int O_PAR0 = 18;
  localparam int O_PROG1 = 19;
  localparam int O_PSEL2 = 20;
  localparam int O_PSEL3 = 21;
  localparam int O_XMEM = 22;
  // Select code values
  localparam logic [4:0] C_ROM = 5'h00;
  localparam logic [4:0] C_KBC = 5'h01;
  localparam logic [4:0] C_NPU = 5'h02;
  localparam logic [4:0] C_PCU0 = 5'h03;
  localparam logic [4:0] C_KACK = 5'h04;
  localparam logic [4:0] C_RTCALE = 5'h05;
  localparam logic [4:0] C_RTCWR = 5'h06;
  localparam logic [4:0] C_RTCRD = 5'h07;
  localparam logic [4:0] C_FDOR = 5'h08;
  localparam logic [4:0] C_FLOPPY = 5'h09;
  localparam logic [4:0] C_FDCR = 5'h0a;
  localparam logic [4:0] C_FDCR_IDE = 5'h0b;
  localparam logic [4:0] C_IDECMD = 5'h0c;
  localparam logic [4:0] C_IDECTL = 5'h0d;
  localparam logic [4:0] C_SERA = 5'h0e;
  localparam logic [4:0] C_PAR0 = 5'h0f;
  localparam logic [4:0] C_SERB = 5'h10;
  localparam logic [4:0] C_PROG1 = 5'h11;
  localparam logic [4:0] C_XMEM = 5'h14;
  localparam logic [4:0] C_SUSPEND = 5'h15;
  localparam logic [4:0] C_RESUME = 5'h16;
  localparam logic [4:0] C_PCU1 = 5'h17;
  localparam logic [4:0] C_RSV0 = 5'h18;
  localparam logic [4:0] C_RSV1 = 5'h19;
  localparam logic [4:0] C_PSEL2 = 5'h1a;
  localparam logic [4:0] C_PSEL3 = 5'h1b;
  // Reset values
  localparam logic [LATCH_W-1:0] LATCH_RST = 6'h20;
  localparam logic [OUT_W-1:0] OUT_RST = 23'h7fffff;
  // Suspend sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SUSPEND = 2'b10
  } susp_state_e;
endpackage

// ---- verif/companion_ctrl.sv ----
// Model of the system controller that drives the select-code lines.
// Assumes the bench calls its tasks; every change lands 1 ns after mclk rises.
`timescale 1ns/1ps
module companion_ctrl
  import select_decode_pkg::*;
(
  input wire logic mclk,
  output logic decodeEnable_n,
  output logic dmaAckDecodeDisable,
  output logic selectCodeBit4,
  output logic selectCodeBit3,
  output logic [2:0] selectCodeBits2_0,
  output logic addrLatchStrobe,
  output logic ioWrite_n,
  output logic ioRead_n,
  output logic addr0,
  output logic busOsc
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Strobe parked high keeps the latch transparent, as when unconnected
  initial
  begin
    decodeEnable_n = 1'b1;
    dmaAckDecodeDisable = 1'b0;
    {selectCodeBit4, selectCodeBit3, selectCodeBits2_0} = 5'h00;
    addrLatchStrobe = 1'b1;
    ioWrite_n = 1'b1;
    ioRead_n = 1'b1;
    addr0 = 1'b1;
    busOsc = 1'b1;
  end
  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // One full request word; all lines move together so none is seen half-changed
  task automatic apply(input logic [CODE_W-1:0] code, input logic enN, input logic dis,
    input logic stb, input logic iowN, input logic iorN, input logic a0);
    @(posedge mclk);
    #1;
    {selectCodeBit4, selectCodeBit3, selectCodeBits2_0} = code;
    decodeEnable_n = enN;
    dmaAckDecodeDisable = dis;
    addrLatchStrobe = stb;
    ioWrite_n = iowN;
    ioRead_n = iorN;
    addr0 = a0;
  endtask
  // A single oscillator fall, the qualifier of both suspend codes
  task automatic osc_fall();
    @(posedge mclk);
    #1;
    busOsc = 1'b0;
    @(posedge mclk);
    #1;
    busOsc = 1'b1;
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the select-code decoder.
// Assumes the companion model drives every decoder input after each edge.
`timescale 1ns/1ps
module tb
  import select_decode_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk; // 100 MHz clock
  logic rst; // Active high reset
  wire decEnN, dis, b4, b3, stb, iowN, iorN, a0, osc;
  wire [2:0] b20;
  wire [OUT_W-1:0] outN; // Outputs gathered in package bit order
  wire clk48Enable;
  int mismatches = 0;
  int n_checks = 0;

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  companion_ctrl ctl (.mclk(mclk), .decodeEnable_n(decEnN), .dmaAckDecodeDisable(dis),
    .selectCodeBit4(b4), .selectCodeBit3(b3), .selectCodeBits2_0(b20), .addrLatchStrobe(stb),
    .ioWrite_n(iowN), .ioRead_n(iorN), .addr0(a0), .busOsc(osc));

  chip_select_code_decoder DUT (.mclk(mclk), .rst(rst), .decodeEnable_n(decEnN),
    .dmaAckDecodeDisable(dis), .selectCodeBit4(b4), .selectCodeBit3(b3),
    .selectCodeBits2_0(b20), .addrLatchStrobe(stb), .ioWrite_n(iowN), .ioRead_n(iorN),
    .addr0(a0), .busOsc(osc), .biosRomOutputEnable_n(outN[O_ROM]),
    .keyboardCtrlSelect_n(outN[O_KBC]), .numericCoprocSelect_n(outN[O_NPU]),
    .powerUnitWriteStrobe0_n(outN[O_PCU0]), .powerUnitWriteStrobe1_n(outN[O_PCU1]),
    .keyboardProcAck_n(outN[O_KACK]), .rtcAddrLatchEnable_n(outN[O_RTCALE]),
    .rtcWriteStrobe_n(outN[O_RTCWR]), .rtcReadStrobe_n(outN[O_RTCRD]),
    .floppyOutputRegSelect_n(outN[O_FDOR]), .floppyCtrlSelect_n(outN[O_FLOPPY]),
    .floppyControlRegSelect_n(outN[O_FDCR]), .driveLowByteBufferEn_n(outN[O_IDEL]),
    .driveHighByteBufferEn_n(outN[O_IDEH]), .driveCmdBlockSelect_n(outN[O_IDECMD]),
    .driveCtrlBlockSelect_n(outN[O_IDECTL]), .serialASelect_n(outN[O_SERA]),
    .serialBSelect_n(outN[O_SERB]), .parallel0Select_n(outN[O_PAR0]),
    .programmableSelect1_n(outN[O_PROG1]), .programmableSelect2_n(outN[O_PSEL2]),
    .programmableSelect3_n(outN[O_PSEL3]), .expandedMemAccess_n(outN[O_XMEM]),
    .clk48Enable(clk48Enable));

  // ----------------------------------------
  // Expectations and compares
  // ----------------------------------------
  // Active-low image of one open decode, built from the code table
  function automatic logic [OUT_W-1:0] exp_n(input logic [4:0] c, input logic w, input logic r,
    input logic lsb);
    logic [OUT_W-1:0] a;
    a = '0;
    case (c)
      5'h00: a[O_ROM] = 1'b1;
      5'h01: a[O_KBC] = 1'b1;
      5'h02: a[O_NPU] = 1'b1;
      5'h03: a[O_PCU0] = 1'b1;
      5'h04: a[O_KACK] = 1'b1;
      5'h05: a[O_RTCALE] = 1'b1;
      5'h06: a[O_RTCWR] = ~w;
      5'h07: a[O_RTCRD] = ~r;
      5'h08: a[O_FDOR] = 1'b1;
      5'h09: a[O_FLOPPY] = 1'b1;
      5'h0a: a[O_FDCR] = 1'b1;
      5'h0b: a = (OUT_W'(1) << O_FDCR) | (OUT_W'(1) << O_IDEL) | (OUT_W'(1) << O_IDECTL);
      5'h0c: a = (OUT_W'(1) << O_IDEL) | (OUT_W'(1) << O_IDECMD) | (OUT_W'(!lsb) << O_IDEH);
      5'h0d: a = (OUT_W'(1) << O_IDEL) | (OUT_W'(1) << O_IDECTL);
      5'h0e: a[O_SERA] = 1'b1;
      5'h0f: a[O_PAR0] = 1'b1;
      5'h10: a[O_SERB] = 1'b1;
      5'h11: a[O_PROG1] = 1'b1;
      5'h14: a[O_XMEM] = 1'b1;
      5'h17: a[O_PCU1] = 1'b1;
      5'h1a: a[O_PSEL2] = 1'b1;
      5'h1b: a[O_PSEL3] = 1'b1;
      default: a = '0; // Reserved and suspend codes select nothing
    endcase
    return ~a;
  endfunction

  task automatic check_vec(input string what, input logic [OUT_W-1:0] e, input logic [OUT_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_bit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask

  // Outputs answer on the edge that samples the request; a second edge is waited as margin
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Closed after reset, even with a valid code present
  task automatic t_reset();
    check_vec("reset outputs", '1, outN);
    check_bit("reset clk48", 1'b1, clk48Enable);
    ctl.apply(5'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("never opened", '1, outN);
    $display("Test reset finished");
  endtask

  // Every code, then the gated and address-qualified ones
  task automatic t_codes();
    for (int c = 0; c < 32; c++)
    begin
      ctl.apply(c[4:0], 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      settle();
      check_vec("decode", exp_n(c[4:0], 1'b1, 1'b1, 1'b1), outN);
    end
    ctl.apply(5'h06, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    check_vec("rtc write", exp_n(5'h06, 1'b0, 1'b1, 1'b1), outN);
    ctl.apply(5'h06, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    check_vec("rtc write no enable", '1, outN);
    ctl.apply(5'h07, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    settle();
    check_vec("rtc read", exp_n(5'h07, 1'b1, 1'b0, 1'b1), outN);
    ctl.apply(5'h0c, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    check_vec("drive high byte", exp_n(5'h0c, 1'b1, 1'b1, 1'b0), outN);
    $display("Test codes finished");
  endtask

  // Stays open after enable rises; disable closes it
  task automatic t_close();
    ctl.apply(5'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("open after enable rise", exp_n(5'h00, 1'b1, 1'b1, 1'b1), outN);
    ctl.apply(5'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("disable dominates", '1, outN);
    ctl.apply(5'h01, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("stays closed", '1, outN);
    $display("Test close finished");
  endtask

  // Strobe fall captures; changes while low are ignored
  task automatic t_latch();
    ctl.apply(5'h01, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    ctl.apply(5'h02, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("held code", exp_n(5'h01, 1'b1, 1'b1, 1'b1), outN);
    ctl.apply(5'h03, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("transparent", exp_n(5'h03, 1'b1, 1'b1, 1'b1), outN);
    $display("Test latch finished");
  endtask

  // Suspend refused without write, entered with it, then resumed
  task automatic t_suspend();
    logic [OUT_W-1:0] ports;
    ports = exp_n(5'h0e, 1'b1, 1'b1, 1'b1) & exp_n(5'h0f, 1'b1, 1'b1, 1'b1) & exp_n(5'h10, 1'b1, 1'b1, 1'b1);
    ctl.apply(5'h15, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    ctl.osc_fall();
    settle();
    check_bit("clk48 without write", 1'b1, clk48Enable);
    check_vec("no suspend", '1, outN);
    ctl.apply(5'h15, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    ctl.osc_fall();
    settle();
    check_bit("clk48 stopped", 1'b0, clk48Enable);
    check_vec("ports held", ports, outN);
    ctl.apply(5'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_vec("frozen code", ports, outN);
    ctl.apply(5'h16, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    settle();
    check_bit("clk48 held without osc fall", 1'b0, clk48Enable);
    ctl.apply(5'h16, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    ctl.osc_fall();
    settle();
    check_bit("clk48 restarted", 1'b1, clk48Enable);
    check_vec("ports released", '1, outN);
    $display("Test suspend finished");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Tests need well under 1000 cycles; allow a wide margin
  initial
  begin
    #50000;
    mismatches++;
    $display("Error watchdog expected finish seen timeout");
    give_verdict();
  end

  initial
  begin
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_codes();
    t_close();
    t_latch();
    t_suspend();
    give_verdict();
  end
endmodule

// ---- verilog/chip_select_code_decoder.sv ----
// Select-code decoder: turns a five-line code from the system controller
// into individual active-low selects, strobes and enables.
// Assumes all inputs are synchronous to mclk; outputs lag by one clock.
//
// Summary of operation
// - Five-bit code decodes to 24 functions.
// - Code is bit4, bit3, then bits 2..0.
// - Nothing asserted until decode enable goes low.
// - DMA acknowledge disable high closes the decoder.
// - Strobe falling edge captures enable and code.
// - Latch is transparent while strobe is high.
// - Codes 0..2: ROM, keyboard, coprocessor selects.
// - 03H power strobe 0, 17H strobe 1.
// - 04H asserts keyboard processor acknowledge.
// - 05H asserts clock address latch enable.
// - 06H clock write, gated by enable, write.
// - 07H clock read, gated by enable, read.
// - 08H output register, 09H floppy select.
// - 0AH floppy control register select only.
// - 0BH control register, low buffer, control block.
// - 0CH command block, high byte if A0 low.
// - 0EH serial A, 0FH parallel, 10H serial B.
// - 11H, 1AH, 1BH programmable selects 1..3.
// - 14H asserts expanded memory access.
// - 15H stops 48 MHz clock, freezes, selects on.
// - 16H restarts clock, releases, selects off.
// - Entry needs enable low, write low, oscillator fall.
// - Exit needs oscillator falling edge.
`timescale 1ns/1ps
module chip_select_code_decoder
  import select_decode_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic decodeEnable_n,
  input wire logic dmaAckDecodeDisable,
  input wire logic selectCodeBit4,
  input wire logic selectCodeBit3,
  input wire logic [2:0] selectCodeBits2_0,
  input wire logic addrLatchStrobe,
  input wire logic ioWrite_n,
  input wire logic ioRead_n,
  input wire logic addr0,
  input wire logic busOsc,
  output logic biosRomOutputEnable_n,
  output logic keyboardCtrlSelect_n,
  output logic numericCoprocSelect_n,
  output logic powerUnitWriteStrobe0_n,
  output logic powerUnitWriteStrobe1_n,
  output logic keyboardProcAck_n,
  output logic rtcAddrLatchEnable_n,
  output logic rtcWriteStrobe_n,
  output logic rtcReadStrobe_n,
  output logic floppyOutputRegSelect_n,
  output logic floppyCtrlSelect_n,
  output logic floppyControlRegSelect_n,
  output logic driveLowByteBufferEn_n,
  output logic driveHighByteBufferEn_n,
  output logic driveCmdBlockSelect_n,
  output logic driveCtrlBlockSelect_n,
  output logic serialASelect_n,
  output logic serialBSelect_n,
  output logic parallel0Select_n,
  output logic programmableSelect1_n,
  output logic programmableSelect2_n,
  output logic programmableSelect3_n,
  output logic expandedMemAccess_n,
  output logic clk48Enable
);
  // ----------------------------------------
  // Input latch
  // ----------------------------------------
  logic [LATCH_W-1:0] liveWord; // Enable and code as driven now
  logic [LATCH_W-1:0] latchedWord; // Enable and code after the latch
  logic [CODE_W-1:0] liveCode; // Unlatched code, watched during suspend
  logic [CODE_W-1:0] code; // Code that drives the decode
  logic enEff_n; // Latched decode enable
  susp_state_e state_r; // Suspend sequencer
  logic frozen; // Latch held while suspended

  // Code bit order puts the high select line on top
  assign liveCode = {selectCodeBit4, selectCodeBit3, selectCodeBits2_0};
  assign liveWord = {decodeEnable_n, liveCode};
  assign frozen = (state_r == ST_SUSPEND);

  code_latch u_latch (
    .mclk(mclk),
    .rst(rst),
    .strobe(addrLatchStrobe),
    .freeze(frozen),
    .liveWord(liveWord),
    .latchedWord(latchedWord)
  );

  assign enEff_n = latchedWord[LATCH_W-1];
  assign code = latchedWord[CODE_W-1:0];

  // ----------------------------------------
  // Open / closed tracking
  // ----------------------------------------
  logic open_r; // Decoder has been opened and not closed since
  logic openNow; // Decode may assert outputs this cycle

  // Enable low opens; disable high closes and wins over a new open
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      open_r <= 1'b0;
    else if (dmaAckDecodeDisable)
      open_r <= 1'b0;
    else if (!enEff_n)
      open_r <= 1'b1;
  end

  // Opening takes effect in the same cycle the enable falls
  assign openNow = (open_r || !enEff_n) && !dmaAckDecodeDisable;

  // ----------------------------------------
  // Bus oscillator edge
  // ----------------------------------------
  logic oscPrev_r; // Oscillator one cycle ago
  logic oscFall; // Falling edge seen this cycle

  // Oscillator is slow against mclk, so a plain compare finds its edges
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      oscPrev_r <= 1'b0;
    else
      oscPrev_r <= busOsc;
  end

  assign oscFall = oscPrev_r && !busOsc;

  // ----------------------------------------
  // Suspend sequencer
  // ----------------------------------------
  logic enterSusp; // Qualified suspend request
  logic leaveSusp; // Qualified resume request

  assign enterSusp = openNow && (code == C_SUSPEND) && !enEff_n && !ioWrite_n && oscFall;
  // The latch is frozen, so resume is watched on the live lines
  assign leaveSusp = (liveCode == C_RESUME) && oscFall;

  // Run until a qualified suspend, then wait for a qualified resume
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_r <= ST_RUN;
    else
    begin
      case (state_r)
        ST_RUN:
        begin
          if (enterSusp)
            state_r <= ST_SUSPEND;
        end
        ST_SUSPEND:
        begin
          if (leaveSusp)
            state_r <= ST_RUN;
        end
        default:
          state_r <= ST_RUN;
      endcase
    end
  end

  // Clock enable for the external 48 MHz source follows the sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clk48Enable <= 1'b1;
    else if (enterSusp && state_r == ST_RUN)
      clk48Enable <= 1'b0;
    else if (leaveSusp && state_r == ST_SUSPEND)
      clk48Enable <= 1'b1;
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [OUT_W-1:0] active; // Active-high form of next outputs
  logic [OUT_W-1:0] out_r; // Registered active-low outputs

  // One code maps to one function group; clock read and write strobes gated by bus cycle
  always_comb
  begin
    active = '0;
    if (frozen)
    begin
      // Ports stay selected for the whole suspend
      active[O_SERA] = 1'b1;
      active[O_SERB] = 1'b1;
      active[O_PAR0] = 1'b1;
    end
    else if (openNow)
    begin
      case (code)
        C_ROM: active[O_ROM] = 1'b1;
        C_KBC: active[O_KBC] = 1'b1;
        C_NPU: active[O_NPU] = 1'b1;
        C_PCU0: active[O_PCU0] = 1'b1;
        C_PCU1: active[O_PCU1] = 1'b1;
        C_KACK: active[O_KACK] = 1'b1;
        C_RTCALE: active[O_RTCALE] = 1'b1;
        C_RTCWR: active[O_RTCWR] = !enEff_n && !ioWrite_n;
        C_RTCRD: active[O_RTCRD] = !enEff_n && !ioRead_n;
        C_FDOR: active[O_FDOR] = 1'b1;
        C_FLOPPY: active[O_FLOPPY] = 1'b1;
        C_FDCR: active[O_FDCR] = 1'b1;
        C_FDCR_IDE:
        begin
          active[O_FDCR] = 1'b1;
          active[O_IDEL] = 1'b1;
          active[O_IDECTL] = 1'b1;
        end
        C_IDECMD:
        begin
          active[O_IDEL] = 1'b1;
          active[O_IDECMD] = 1'b1;
          active[O_IDEH] = !addr0;
        end
        C_IDECTL:
        begin
          active[O_IDEL] = 1'b1;
          active[O_IDECTL] = 1'b1;
        end
        C_SERA: active[O_SERA] = 1'b1;
        C_PAR0: active[O_PAR0] = 1'b1;
        C_SERB: active[O_SERB] = 1'b1;
        C_PROG1: active[O_PROG1] = 1'b1;
        C_PSEL2: active[O_PSEL2] = 1'b1;
        C_PSEL3: active[O_PSEL3] = 1'b1;
        C_XMEM: active[O_XMEM] = 1'b1;
        // Reserved and unused codes, and the suspend codes, select nothing
        default: active = '0;
      endcase
    end
  end

  // Outputs come from flops, inverted to active low per bit
  genvar gi;
  generate
    for (gi = 0; gi < OUT_W; gi++)
    begin : g_out
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          out_r[gi] <= OUT_RST[gi];
        else
          out_r[gi] <= !active[gi];
      end
    end
  endgenerate

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  assign biosRomOutputEnable_n = out_r[O_ROM];
  assign keyboardCtrlSelect_n = out_r[O_KBC];
  assign numericCoprocSelect_n = out_r[O_NPU];
  assign powerUnitWriteStrobe0_n = out_r[O_PCU0];
  assign powerUnitWriteStrobe1_n = out_r[O_PCU1];
  assign keyboardProcAck_n = out_r[O_KACK];
  assign rtcAddrLatchEnable_n = out_r[O_RTCALE];
  assign rtcWriteStrobe_n = out_r[O_RTCWR];
  assign rtcReadStrobe_n = out_r[O_RTCRD];
  assign floppyOutputRegSelect_n = out_r[O_FDOR];
  assign floppyCtrlSelect_n = out_r[O_FLOPPY];
  assign floppyControlRegSelect_n = out_r[O_FDCR];
  assign driveLowByteBufferEn_n = out_r[O_IDEL];
  assign driveHighByteBufferEn_n = out_r[O_IDEH];
  assign driveCmdBlockSelect_n = out_r[O_IDECMD];
  assign driveCtrlBlockSelect_n = out_r[O_IDECTL];
  assign serialASelect_n = out_r[O_SERA];
  assign serialBSelect_n = out_r[O_SERB];
  assign parallel0Select_n = out_r[O_PAR0];
  assign programmableSelect1_n = out_r[O_PROG1];
  assign programmableSelect2_n = out_r[O_PSEL2];
  assign programmableSelect3_n = out_r[O_PSEL3];
  assign expandedMemAccess_n = out_r[O_XMEM];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_closed;
    @(posedge mclk) disable iff (rst)
      (!openNow && !frozen) |=> (out_r == OUT_RST);
  endproperty
  a_closed: assert property (p_closed) else $error("Output active with decoder closed");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
      (!frozen && (code == C_RSV0 || code == C_RSV1)) |=> (out_r == OUT_RST);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved code asserted an output");

  property p_rom;
    @(posedge mclk) disable iff (rst)
      (openNow && !frozen && code == C_ROM) |=> (!biosRomOutputEnable_n && keyboardCtrlSelect_n);
  endproperty
  a_rom: assert property (p_rom) else $error("ROM enable not asserted for code 00");

  property p_pcu1;
    @(posedge mclk) disable iff (rst)
      (openNow && !frozen && code == C_PCU1) |=> (!powerUnitWriteStrobe1_n && powerUnitWriteStrobe0_n);
  endproperty
  a_pcu1: assert property (p_pcu1) else $error("Power strobe 1 wrong for code 17");

  property p_rtcwr;
    @(posedge mclk) disable iff (rst)
      !rtcWriteStrobe_n |-> $past(openNow && code == C_RTCWR && !ioWrite_n && !enEff_n);
  endproperty
  a_rtcwr: assert property (p_rtcwr) else $error("Clock write strobe without gated write");

  property p_rtcrd;
    @(posedge mclk) disable iff (rst)
      !rtcReadStrobe_n |-> $past(openNow && code == C_RTCRD && !ioRead_n && !enEff_n);
  endproperty
  a_rtcrd: assert property (p_rtcrd) else $error("Clock read strobe without gated read");

  property p_hibyte;
    @(posedge mclk) disable iff (rst)
      (openNow && !frozen && code == C_IDECMD) |=> (driveHighByteBufferEn_n == $past(addr0)) && !driveCmdBlockSelect_n;
  endproperty
  a_hibyte: assert property (p_hibyte) else $error("High byte enable not tied to A0");

  property p_disable;
    @(posedge mclk) disable iff (rst)
      dmaAckDecodeDisable |=> !open_r;
  endproperty
  a_disable: assert property (p_disable) else $error("Decoder stayed open after disable");

  property p_suspend;
    @(posedge mclk) disable iff (rst)
      (state_r == ST_RUN && enterSusp) |=> (!clk48Enable && frozen) ##1 (!serialASelect_n && !parallel0Select_n);
  endproperty
  a_suspend: assert property (p_suspend) else $error("Suspend entry did not stop clock");

  property p_resume;
    @(posedge mclk) disable iff (rst)
      (frozen && leaveSusp) |=> (clk48Enable && !frozen)
        ##1 (serialBSelect_n || ($past(openNow) && $past(code) == C_SERB));
  endproperty
  a_resume: assert property (p_resume) else $error("Resume did not restart clock");
endmodule

// ---- verilog/code_latch.sv ----
// Address-strobe controlled latch for the enable and select code lines.
// Assumes the strobe is tied high by the user when latching is not wanted.
`timescale 1ns/1ps
module code_latch
  import select_decode_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic strobe, // Address latch strobe, transparent while high
  input wire logic freeze, // Hold the word regardless of the strobe
  input wire logic [LATCH_W-1:0] liveWord,
  output logic [LATCH_W-1:0] latchedWord
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [LATCH_W-1:0] held_r; // Last word seen while transparent

  // Follow the inputs while open; the last value before the fall is kept
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      held_r <= LATCH_RST;
    else if (strobe && !freeze)
      held_r <= liveWord;
  end

  // Transparent path avoids a cycle of delay when latching is unused
  assign latchedWord = (strobe && !freeze) ? liveWord : held_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_capture;
    @(posedge mclk) disable iff (rst)
      ($fell(strobe) && !$past(freeze)) |-> (latchedWord == $past(liveWord));
  endproperty
  a_capture: assert property (p_capture) else $error("Code not captured at strobe fall");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      (!strobe && !$past(strobe) && !freeze) |-> $stable(latchedWord);
  endproperty
  a_hold: assert property (p_hold) else $error("Latched code moved while strobe low");

  property p_pass;
    @(posedge mclk) disable iff (rst)
      (strobe && !freeze) |=> (!strobe || freeze || held_r == $past(liveWord));
  endproperty
  a_pass: assert property (p_pass) else $error("Latch not transparent with strobe high");
endmodule
